// >>> hw/mrm_cfg.svh
// constants of the receive-mapping block: field widths, codes and timing
// assumes inclusion by bare name from each design file that uses its macros
`ifndef MRM_CFG_SVH
`define MRM_CFG_SVH
`define MRM_NBANK 4
`define MRM_CH_OMNI 5'h10
`define MRM_CH_OFF 5'h11
`define MRM_MEM_EMPTY 7'h7f
`define MRM_MEM_RAM_LO 7'h3d
`define MRM_MEM_RAM_HI 7'h5a
`define MRM_SRC_OFF 2'h0
`define MRM_SRC_CC 2'h1
`define MRM_SRC_VEL 2'h2
`define MRM_SRC_PRESS 2'h3
`define MRM_ST_NOTE_ON 4'h9
`define MRM_ST_CC 4'hb
`define MRM_ST_PGM 4'hc
`define MRM_ST_PRESS 4'hd
`define MRM_HOLD_MS 1000
`define MRM_CLK_MHZ 200
`define MRM_NUTIL 5
`define MRM_A_BANK 8'h00
`define MRM_A_CH0 8'h04
`define MRM_A_CTL1 8'h14
`define MRM_A_CTL2 8'h18
`define MRM_A_PGM 8'h1c
`define MRM_A_STAT 8'h20
`define MRM_A_TBL 12'h400
`endif

// >>> hw/mrm_hold_timer.sv
// utility key hold timer: pulses once when the key has been held long enough
// assumes key level synchronous to clk_sys_i
`timescale 1ns/10ps
`default_nettype none
`include "mrm_cfg.svh"
module mrm_hold_timer #(
  parameter int unsigned HOLD_CYCLES = `MRM_HOLD_MS * `MRM_CLK_MHZ * 1000
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // key
  input wire logic key_i,
  output logic hold_o
);
  // a count below two would fire on the press edge itself
  if (HOLD_CYCLES < 2) begin : g_bad_hold
    $error("hold count too small");
  end
  typedef struct packed {
    logic [31:0] cnt;
    logic fired;
  } mrm_ht_s;
  mrm_ht_s st_r, st_nxt;
  always_comb begin
    st_nxt = st_r;
    if (!key_i) begin
      st_nxt.cnt = 32'h0000_0000;
      st_nxt.fired = 1'b0;
    end else if (!st_r.fired) begin
      if (st_r.cnt == HOLD_CYCLES - 1) st_nxt.fired = 1'b1;
      else st_nxt.cnt = st_r.cnt + 32'h0000_0001;
    end
  end
  assign hold_o = key_i && !st_r.fired && (st_r.cnt == HOLD_CYCLES - 1);
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) st_r <= '0;
    else st_r <= st_nxt;
  end
endmodule // mrm_hold_timer
`default_nettype wire

// >>> hw/mrm_pkg.sv
// types of the receive-mapping block
// assumes mrm_cfg.svh sits beside it
package mrm_pkg;
  typedef enum logic [2:0] {
    MRM_UT_OFF = 3'b000,
    MRM_UT_TITLE = 3'b001,
    MRM_UT_SETUP = 3'b011,
    MRM_UT_PGM = 3'b010,
    MRM_UT_CC1 = 3'b110,
    MRM_UT_CC2 = 3'b111
  } mrm_util_e;
  typedef enum logic [1:0] {
    MRM_PS_IDLE = 2'b00,
    MRM_PS_D1 = 2'b01,
    MRM_PS_D2 = 2'b11
  } mrm_parse_e;
endpackage

// >>> hw/mrm_receive_map.sv
// midi receive mapping: byte parser, bank tables, controller binding, utility sequencing
// assumes midi bytes arrive as valid-qualified bytes on clk_sys_i; apb master on same clock
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
`include "mrm_cfg.svh"
module mrm_receive_map
  import mrm_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `MRM_HOLD_MS * `MRM_CLK_MHZ * 1000
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // midi byte stream
  input wire logic midi_valid_i,
  input wire logic [7:0] midi_byte_i,
  // front panel
  input wire logic util_key_i,
  input wire logic assign_select_i,
  input wire logic parameter_edit_mode_mode_i,
  input wire logic [6:0] ctl1_parameter_edit_mode_i,
  input wire logic [6:0] ctl2_parameter_edit_mode_i,
  // results
  output logic [6:0] memory_sel_o,
  output logic recall_o,
  output logic [6:0] ctl1_value_o,
  output logic ctl1_upd_o,
  output logic [6:0] ctl2_value_o,
  output logic ctl2_upd_o,
  output logic [2:0] util_func_o,
  output logic util_led_o,
  output logic parameter_edit_mode_o,
  output logic title_refused_o,
  output logic title_save_o
);
  typedef struct packed {
    mrm_parse_e ps;
    logic [3:0] stat;
    logic [3:0] chan;
    logic [6:0] d1;
    logic [1:0] bank;
    logic [3:0][4:0] rx_ch;
    logic [7:0] ctl1;
    logic [7:0] ctl2;
    logic [6:0] mem;
    logic recall;
    logic [6:0] v1;
    logic [6:0] v2;
    logic u1;
    logic u2;
    logic [6:0] best_note;
    logic note_seen;
    mrm_util_e util;
    logic prev_parameter_edit_mode;
    logic refused;
    logic save;
  } mrm_st_s;
  mrm_st_s st_r, st_nxt;
  // program tables: bank*128+program, flip-flop storage
  logic [6:0] tbl_r [0:511];
  logic hold_pulse;
  logic [6:0] midi_data;
  logic bus_wr, bus_rd, tbl_hit, tbl_we, pgm_done;
  logic [4:0] cur_ch;
  logic ch_ok, ctl_ok;
  logic [6:0] tbl_rd_val;
  logic [6:0] mapped;
  mrm_hold_timer #(.HOLD_CYCLES(HOLD_CYCLES)) u_hold (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .key_i(util_key_i),
    .hold_o(hold_pulse)
  );
  // key press edge
  logic key_d_r;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) key_d_r <= 1'b0;
    else key_d_r <= util_key_i;
  end
  // =====================================================================
  // apb decode
  assign midi_data = midi_byte_i[6:0];
  assign bus_wr = psel && penable && pwrite;
  assign bus_rd = psel && !pwrite;
  assign tbl_hit = paddr[11:10] == 2'(`MRM_A_TBL >> 10);
  // single-cycle access phase
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign tbl_we = bus_wr && tbl_hit;
  assign tbl_rd_val = tbl_r[{st_r.bank, paddr[8:2]}];
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) prdata <= 32'h0000_0000;
    else if (bus_rd && !penable) begin
      prdata <= 32'h0000_0000;
      if (tbl_hit) prdata <= {25'h000_0000, tbl_rd_val};
      else case (paddr[7:0])
        `MRM_A_BANK: prdata <= {30'h0000_0000, st_r.bank};
        `MRM_A_CH0: prdata <= {27'h000_0000, st_r.rx_ch[0]};
        `MRM_A_CH0 + 8'h04: prdata <= {27'h000_0000, st_r.rx_ch[1]};
        `MRM_A_CH0 + 8'h08: prdata <= {27'h000_0000, st_r.rx_ch[2]};
        `MRM_A_CH0 + 8'h0c: prdata <= {27'h000_0000, st_r.rx_ch[3]};
        `MRM_A_CTL1: prdata <= {24'h00_0000, st_r.ctl1};
        `MRM_A_CTL2: prdata <= {24'h00_0000, st_r.ctl2};
        `MRM_A_PGM: prdata <= {25'h000_0000, st_r.mem};
        `MRM_A_STAT: prdata <= {18'h0_0000, st_r.v2, st_r.v1};
        default: prdata <= 32'h0000_0000;
      endcase
    end
  end
  // =====================================================================
  // table storage
  generate
    for (genvar gi = 0; gi < 512; gi++) begin : g_tbl
      always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) tbl_r[gi] <= `MRM_MEM_EMPTY;
        else if (tbl_we && ({st_r.bank, paddr[8:2]} == 9'(gi))) tbl_r[gi] <= pwdata[6:0];
      end
    end
  endgenerate
  // =====================================================================
  // receive filter
  assign cur_ch = st_r.rx_ch[st_r.bank];
  always_comb begin
    ch_ok = 1'b0;
    if (cur_ch == `MRM_CH_OMNI) ch_ok = 1'b1;
    else if (cur_ch != `MRM_CH_OFF) ch_ok = cur_ch[3:0] == st_r.chan;
  end
  assign ctl_ok = ch_ok && !assign_select_i;
  assign mapped = tbl_r[{st_r.bank, midi_data}];
  assign pgm_done = midi_valid_i && !midi_byte_i[7] && st_r.ps == MRM_PS_D1 && st_r.stat == `MRM_ST_PGM;
  // =====================================================================
  // main state
  always_comb begin
    st_nxt = st_r;
    st_nxt.recall = 1'b0;
    st_nxt.u1 = 1'b0;
    st_nxt.u2 = 1'b0;
    st_nxt.save = 1'b0;
    // register writes
    if (bus_wr && !tbl_hit) begin
      case (paddr[7:0])
        `MRM_A_BANK: st_nxt.bank = pwdata[1:0];
        `MRM_A_CH0: st_nxt.rx_ch[0] = pwdata[4:0];
        `MRM_A_CH0 + 8'h04: st_nxt.rx_ch[1] = pwdata[4:0];
        `MRM_A_CH0 + 8'h08: st_nxt.rx_ch[2] = pwdata[4:0];
        `MRM_A_CH0 + 8'h0c: st_nxt.rx_ch[3] = pwdata[4:0];
        `MRM_A_CTL1: st_nxt.ctl1 = pwdata[7:0];
        `MRM_A_CTL2: st_nxt.ctl2 = pwdata[7:0];
        default: st_nxt.bank = st_r.bank;
      endcase
    end
    // parser; status bytes 0xf8+ are realtime and skipped
    if (midi_valid_i) begin
      if (midi_byte_i[7]) begin
        if (midi_byte_i[7:3] != 5'b11111) begin
          st_nxt.stat = midi_byte_i[7:4];
          st_nxt.chan = midi_byte_i[3:0];
          st_nxt.ps = MRM_PS_D1;
          if (midi_byte_i[7:4] != `MRM_ST_NOTE_ON) st_nxt.note_seen = 1'b0;
        end
      end else if (st_r.ps == MRM_PS_D1) begin
        st_nxt.d1 = midi_data;
        st_nxt.ps = MRM_PS_D2;
        if (st_r.stat == `MRM_ST_PGM) begin
          st_nxt.ps = MRM_PS_D1;
          if (ch_ok && mapped != `MRM_MEM_EMPTY) begin
            st_nxt.mem = mapped;
            st_nxt.recall = 1'b1;
          end
        end else if (st_r.stat == `MRM_ST_PRESS) begin
          st_nxt.ps = MRM_PS_D1;
          if (ctl_ok && st_r.ctl1[7:6] == `MRM_SRC_PRESS) begin
            st_nxt.v1 = midi_data;
            st_nxt.u1 = 1'b1;
          end
          if (ctl_ok && st_r.ctl2[7:6] == `MRM_SRC_PRESS) begin
            st_nxt.v2 = midi_data;
            st_nxt.u2 = 1'b1;
          end
        end else if (st_r.stat[3] == 1'b0 || st_r.stat[3:1] == 3'b111) st_nxt.ps = MRM_PS_IDLE;
      end else if (st_r.ps == MRM_PS_D2) begin
        st_nxt.ps = MRM_PS_D1; // running status
        if (st_r.stat == `MRM_ST_CC && ctl_ok) begin
          // ctl field: [7:6]=source, [6:0] number whenever bit7=0 (source off or cc)
          if (!st_r.ctl1[7] && st_r.ctl1[6:0] == st_r.d1) begin
            st_nxt.v1 = midi_data;
            st_nxt.u1 = 1'b1;
          end
          if (!st_r.ctl2[7] && st_r.ctl2[6:0] == st_r.d1) begin
            st_nxt.v2 = midi_data;
            st_nxt.u2 = 1'b1;
          end
        end
        if (st_r.stat == `MRM_ST_NOTE_ON && ctl_ok && midi_data != 7'h00) begin
          // chord under running status: keep the highest note seen so far
          if (!st_r.note_seen || st_r.d1 >= st_r.best_note) begin
            st_nxt.best_note = st_r.d1;
            st_nxt.note_seen = 1'b1;
            if (st_r.ctl1[7:6] == `MRM_SRC_VEL) begin
              st_nxt.v1 = midi_data;
              st_nxt.u1 = 1'b1;
            end
            if (st_r.ctl2[7:6] == `MRM_SRC_VEL) begin
              st_nxt.v2 = midi_data;
              st_nxt.u2 = 1'b1;
            end
          end
        end
      end
    end
    // utility sequencing
    if (hold_pulse && st_r.util != MRM_UT_OFF) begin
      st_nxt.util = MRM_UT_OFF;
      st_nxt.save = st_r.util == MRM_UT_TITLE && !st_r.refused;
    end else if (util_key_i && !key_d_r) begin
      st_nxt.refused = 1'b0;
      unique case (st_r.util)
        MRM_UT_OFF: begin
          st_nxt.util = MRM_UT_TITLE;
          st_nxt.prev_parameter_edit_mode = parameter_edit_mode_mode_i;
          st_nxt.refused = st_r.mem < `MRM_MEM_RAM_LO || st_r.mem > `MRM_MEM_RAM_HI;
        end
        MRM_UT_TITLE: begin
          st_nxt.util = MRM_UT_SETUP;
          st_nxt.save = !st_r.refused;
        end
        MRM_UT_SETUP: st_nxt.util = MRM_UT_PGM;
        MRM_UT_PGM: st_nxt.util = MRM_UT_CC1;
        MRM_UT_CC1: st_nxt.util = MRM_UT_CC2;
        MRM_UT_CC2: st_nxt.util = MRM_UT_OFF;
        default: st_nxt.util = MRM_UT_OFF;
      endcase
    end
  end
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      st_r <= '0;
      st_r.ps <= MRM_PS_IDLE;
      st_r.util <= MRM_UT_OFF;
      st_r.rx_ch <= {4{`MRM_CH_OMNI}};
    end else st_r <= st_nxt;
  end
  // =====================================================================
  // outputs; controller 1 takes priority when both drive one parameter
  assign memory_sel_o = st_r.mem;
  assign recall_o = st_r.recall;
  assign ctl1_value_o = st_r.v1;
  assign ctl1_upd_o = st_r.u1;
  assign ctl2_value_o = st_r.v2;
  assign ctl2_upd_o = st_r.u2 && !(st_r.u1 && ctl1_parameter_edit_mode_i == ctl2_parameter_edit_mode_i);
  assign util_func_o = st_r.util;
  assign util_led_o = st_r.util != MRM_UT_OFF;
  assign parameter_edit_mode_o = st_r.util == MRM_UT_OFF && st_r.prev_parameter_edit_mode;
  assign title_refused_o = st_r.util == MRM_UT_TITLE && st_r.refused;
  assign title_save_o = st_r.save;
endmodule // mrm_receive_map
`default_nettype wire

// >>> tb/mrm_midi_src.sv
// far-side model: a keyboard or foot controller sending midi bytes
// assumes the bench calls send() right after a rising edge of clk_sys_i
`timescale 1ns/10ps
`default_nettype none
module mrm_midi_src (
  // clock
  input wire logic clk_sys_i,
  // byte stream
  output logic valid_o,
  output logic [7:0] byte_o
);
  initial begin
    valid_o = '0;
    byte_o = 8'h00;
  end
  // note-on status: upper nibble 1001, channel 1..16 as 0..15
  function automatic logic [7:0] note_on(logic [4:0] ch);
    return {4'h9, 4'(ch - 5'h01)};
  endfunction
  // released line shows the inverse so a stale byte is never seen
  task automatic send(logic [7:0] b);
    valid_o <= 1'b1;
    byte_o <= b;
    @(posedge clk_sys_i);
    valid_o <= 1'b0;
    byte_o <= ~b;
    @(posedge clk_sys_i);
  endtask
endmodule // mrm_midi_src
`default_nettype wire

// >>> tb/mrm_receive_map_chk.sv
// checker for the receive-mapping block, bound onto its top module
// assumes one clock domain and the top module's port names
`timescale 1ns/10ps
`default_nettype none
`include "mrm_cfg.svh"
module mrm_receive_map_chk
  import mrm_pkg::*;
#(
  parameter int unsigned HOLD_CYCLES = `MRM_HOLD_MS * `MRM_CLK_MHZ * 1000
) (
  // clock, reset and inputs
  input wire logic clk_sys_i,
  input wire logic resetn_i,
  input wire logic midi_valid_i,
  input wire logic util_key_i,
  input wire logic assign_select_i,
  input wire logic [6:0] ctl1_parameter_edit_mode_i,
  input wire logic [6:0] ctl2_parameter_edit_mode_i,
  // outputs watched
  input wire logic [6:0] memory_sel_o,
  input wire logic recall_o,
  input wire logic ctl1_upd_o,
  input wire logic ctl2_upd_o,
  input wire logic [2:0] util_func_o,
  input wire logic util_led_o,
  input wire logic title_refused_o,
  input wire logic title_save_o
);
  // ==========================================================
  // key hold counter, saturating so it never wraps
  logic [31:0] hold_cnt_r;
  logic [31:0] hold_cnt_nxt;
  always_comb hold_cnt_nxt = !util_key_i ? '0 : (hold_cnt_r > HOLD_CYCLES + 8) ? hold_cnt_r : hold_cnt_r + 1;
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) hold_cnt_r <= '0;
    else hold_cnt_r <= hold_cnt_nxt;
  end
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence rom_title_s;
    util_func_o == MRM_UT_TITLE && (memory_sel_o < `MRM_MEM_RAM_LO || memory_sel_o > `MRM_MEM_RAM_HI);
  endsequence
  AST_RECALL_AFTER_BYTE: assert property (recall_o |-> $past(midi_valid_i))
    else $error("recall without a midi byte one cycle before");
  AST_MEM_ONLY_ON_RECALL: assert property ($changed(memory_sel_o) |-> recall_o)
    else $error("memory changed without a recall");
  AST_CC_IGNORED_ASSIGN: assert property (ctl1_upd_o |-> $past(midi_valid_i) && !$past(assign_select_i))
    else $error("controller 1 updated while assignment was being chosen");
  AST_CTL1_PRIORITY: assert property (ctl1_upd_o && ctl2_upd_o |-> ctl1_parameter_edit_mode_i != ctl2_parameter_edit_mode_i)
    else $error("both controllers updated the same parameter");
  AST_LED_IN_UTIL: assert property (util_func_o != 3'h0 |-> util_led_o)
    else $error("utility function active with indicator off");
  AST_HOLD_EXIT: assert property (hold_cnt_r == HOLD_CYCLES + 6 |-> !util_led_o && util_func_o == 3'h0)
    else $error("held utility key did not leave utility mode");
  AST_TITLE_REFUSE: assert property (rom_title_s [*2] |-> title_refused_o)
    else $error("title edit on read-only memory not refused");
  AST_SAVE_ON_LEAVE: assert property (title_save_o |-> $past(util_func_o) == MRM_UT_TITLE ||
    $past(util_func_o, 2) == MRM_UT_TITLE)
    else $error("title save outside leaving title edit");
endmodule // mrm_receive_map_chk
bind mrm_receive_map mrm_receive_map_chk #(.HOLD_CYCLES(HOLD_CYCLES)) chk_u (
  .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .midi_valid_i(midi_valid_i), .util_key_i(util_key_i),
  .assign_select_i(assign_select_i), .ctl1_parameter_edit_mode_i(ctl1_parameter_edit_mode_i), .ctl2_parameter_edit_mode_i(ctl2_parameter_edit_mode_i),
  .memory_sel_o(memory_sel_o), .recall_o(recall_o), .ctl1_upd_o(ctl1_upd_o), .ctl2_upd_o(ctl2_upd_o),
  .util_func_o(util_func_o), .util_led_o(util_led_o), .title_refused_o(title_refused_o),
  .title_save_o(title_save_o)
);
`default_nettype wire

// >>> tb/tb_midi_receive_mapping.sv
// bench for the receive-mapping block: apb and midi tasks, directed checks
// assumes design, partner model and checker are compiled before it
`timescale 1ns/10ps
`default_nettype none
`include "mrm_cfg.svh"
module tb_midi_receive_mapping
  import mrm_pkg::*;
;
  // short hold count keeps the run brief
  localparam int unsigned HC = 50;
  logic clk_sys_i = '0;
  logic resetn_i = '0;
  logic psel = '0, penable = '0, pwrite = '0, key = '0, asel = '0, pmode = '0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, rd, prdata;
  logic pready, pslverr, mv, rcl, u1, u2, led, pem, tref, tsav;
  logic [6:0] p1 = 7'h01, p2 = 7'h02, mem, v1, v2;
  logic [7:0] mb;
  logic [2:0] uf;
  int bad_count = 0, num_checks = 0, saves = 0, u2s = 0;
  mrm_util_e seq [6] = '{MRM_UT_TITLE, MRM_UT_SETUP, MRM_UT_PGM, MRM_UT_CC1, MRM_UT_CC2, MRM_UT_OFF};
  always #2.5 clk_sys_i = ~clk_sys_i;
  always @(posedge clk_sys_i) if (tsav === 1'b1) saves <= saves + 1;
  always @(posedge clk_sys_i) if (u2 === 1'b1) u2s <= u2s + 1;
  mrm_receive_map #(.HOLD_CYCLES(HC)) dut_u (
    .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .midi_valid_i(mv), .midi_byte_i(mb), .util_key_i(key), .assign_select_i(asel),
    .parameter_edit_mode_mode_i(pmode), .ctl1_parameter_edit_mode_i(p1), .ctl2_parameter_edit_mode_i(p2), .memory_sel_o(mem),
    .recall_o(rcl), .ctl1_value_o(v1), .ctl1_upd_o(u1), .ctl2_value_o(v2), .ctl2_upd_o(u2),
    .util_func_o(uf), .util_led_o(led), .parameter_edit_mode_o(pem),
    .title_refused_o(tref), .title_save_o(tsav)
  );
  mrm_midi_src src_u (.clk_sys_i(clk_sys_i), .valid_o(mv), .byte_o(mb));
  // ==========================================================
  // tasks
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(string n, logic [31:0] e, logic [31:0] s);
    num_checks++;
    if (s !== e) begin
      bad_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, s);
    end
  endtask
  // one apb transfer; an idle cycle follows so psel is never reassigned at the same edge
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys_i);
    penable <= 1'b1;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 16) begin
      bad_count++;
      give_verdict();
    end
    @(posedge clk_sys_i);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic rdc(string n, logic [11:0] a, logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, e, rd);
  endtask
  task automatic msg(logic [7:0] a, logic [7:0] b, logic [7:0] c, int k);
    src_u.send(a);
    src_u.send(b);
    if (k == 3) src_u.send(c);
    repeat (3) @(posedge clk_sys_i);
  endtask
  task automatic press(int n);
    key <= 1'b1;
    repeat (n) @(posedge clk_sys_i);
    key <= 1'b0;
    repeat (4) @(posedge clk_sys_i);
  endtask
  // ==========================================================
  // main sequence
  initial begin
    repeat (4) @(posedge clk_sys_i);
    resetn_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc("rx_ch_a", `MRM_A_CH0, 32'h0000_0010);
    rdc("entry", `MRM_A_TBL + 12'h014, 32'h0000_007f);
    for (int b = 3; b >= 0; b--) begin
      wr(`MRM_A_BANK, 32'(b));
      wr(`MRM_A_TBL + 12'h014, 32'h0000_003d + 32'(b));
    end
    for (int b = 0; b < 4; b++) begin
      wr(`MRM_A_BANK, 32'(b));
      msg(8'hc0, 8'h05, 8'h00, 2);
      chk("mem_bank", 32'h0000_003d + 32'(b), 32'(mem));
    end
    wr(`MRM_A_TBL + 12'h1fc, 32'h0000_005a);
    msg(8'hc0, 8'h7f, 8'h00, 2);
    chk("mem_pgm128", 32'h0000_005a, 32'(mem));
    wr(`MRM_A_BANK, 32'h0000_0000);
    rdc("entry_a", `MRM_A_TBL + 12'h1fc, 32'h0000_007f);
    msg(8'hc0, 8'h09, 8'h00, 2);
    chk("mem_empty", 32'h0000_005a, 32'(mem));
    $display("test done: banks");
    wr(`MRM_A_CH0, 32'h0000_0002);
    wr(`MRM_A_TBL + 12'h018, 32'h0000_000a);
    msg(8'hc0, 8'h05, 8'h00, 2);
    chk("mem_wrong_ch", 32'h0000_005a, 32'(mem));
    msg(8'hc2, 8'h05, 8'h00, 2);
    chk("mem_ch3", 32'h0000_003d, 32'(mem));
    wr(`MRM_A_CH0, 32'h0000_0011);
    msg(8'hc2, 8'h06, 8'h00, 2);
    chk("mem_off", 32'h0000_003d, 32'(mem));
    wr(`MRM_A_CH0, 32'h0000_0002);
    $display("test done: channels");
    wr(`MRM_A_CTL1, 32'h0000_0007);
    wr(`MRM_A_CTL2, 32'h0000_0007);
    msg(8'hb0, 8'h07, 8'h33, 3);
    chk("v1_other_ch", 32'h0000_0000, 32'(v1));
    msg(8'hb2, 8'h07, 8'h44, 3);
    chk("v1_cc", 32'h0000_0044, 32'(v1));
    chk("v2_cc", 32'h0000_0044, 32'(v2));
    asel <= 1'b1;
    msg(8'hb2, 8'h07, 8'h11, 3);
    chk("v1_assign", 32'h0000_0044, 32'(v1));
    asel <= 1'b0;
    p2 <= 7'h01;
    msg(8'hb2, 8'h07, 8'h22, 3);
    chk("v1_prio", 32'h0000_0022, 32'(v1));
    chk("u2_prio", 32'h0000_0001, 32'(u2s));
    wr(`MRM_A_CTL1, 32'h0000_0080);
    wr(`MRM_A_CTL2, 32'h0000_00c0);
    msg(src_u.note_on(5'h03), 8'h3c, 8'h20, 3);
    msg(8'h40, 8'h30, 8'h00, 2);
    msg(8'h32, 8'h40, 8'h00, 2);
    chk("v1_velocity", 32'h0000_0030, 32'(v1));
    msg(8'hd2, 8'h55, 8'h00, 2);
    chk("v2_pressure", 32'h0000_0055, 32'(v2));
    $display("test done: controllers");
    pmode <= 1'b1;
    foreach (seq[i]) begin
      press(3);
      chk("util_func", 32'(seq[i]), 32'(uf));
      if (i == 0) chk("refused_ram", 32'h0000_0000, 32'(tref));
    end
    chk("saves", 32'h0000_0001, 32'(saves));
    chk("parameter_edit_mode_mode", 32'h0000_0001, 32'(pem));
    msg(8'hc2, 8'h06, 8'h00, 2);
    press(3);
    chk("refused_rom", 32'h0000_0001, 32'(tref));
    press(HC + 10);
    chk("led_hold", 32'h0000_0000, 32'(led));
    chk("func_hold", 32'h0000_0000, 32'(uf));
    chk("saves_rom", 32'h0000_0001, 32'(saves));
    $display("test done: utility");
    give_verdict();
  end
endmodule // tb_midi_receive_mapping
`default_nettype wire
